//--- core/iopc_port.sv
`timescale 1ns/10ps
// Behaviour
// [RL1] Each port keeps ten control registers, from readback to open drain.
// [RL2] Enabled peripheral takes pin from latch; pin level still readable.
// [RL3] Write to latch address equals write to readback address.
// [RL4] Latch read gives stored latch; readback read gives pin levels.
// [RL5] Analog select set disables that pin's digital input buffer.
// [RL6] Current control acts on source and sink drivers, each per pin.
// [RL7] Current control applies whether latch or peripheral drives pin.
// [RL8] One global register holds master enable and current level select.
// [RL9] Separate per-pin enables for source and for sink current control.
// [RL10] After reset every pin output comes from the data latch.
// [RL11] Analog inputs active only while the pin's analog select is set.
// [RL12] Analog select does not stop digital output drive.
// [RL13] Enabled analog output forces digital driver to high impedance.
// [RL14] Direction one disables driver; zero drives latch value on pin. Direction is ignored on pins whose peripheral enable is set.
// [RL15] Analog pin reads zero through digital readback.
// [RL16] Level 11 is 1 mA, 10 is 2 mA, 01 is 5 mA, 00 is 10 mA.
// [RL17] Pin readback passes through a two-stage synchroniser.
module iopc_port (
  // Clock and reset.
  input  wire logic                    sys_clk_i,
  input  wire logic                    nrst_i,
  // Software write strobes, one per register.
  input  wire logic                    wr_readback_i,
  input  wire logic                    wr_latch_i,
  input  wire logic                    wr_dir_i,
  input  wire logic                    wr_ansel_i,
  input  wire logic                    wr_pullup_i,
  input  wire logic                    wr_src_cc_i,
  input  wire logic                    wr_snk_cc_i,
  input  wire logic                    wr_thresh_i,
  input  wire logic                    wr_slew_i,
  input  wire logic                    wr_odrain_i,
  input  wire logic                    wr_ccfg_i,
  input  wire logic [7:0]              wr_data_i,
  // Register contents seen by software.
  output logic [7:0]                   pin_level_readback_o,
  output logic [7:0]                   output_latch_o,
  output logic [7:0]                   direction_control_o,
  output logic [7:0]                   analog_select_o,
  output logic [7:0]                   weak_pullup_enable_o,
  output logic [7:0]                   source_current_limit_enable_o,
  output logic [7:0]                   sink_current_limit_enable_o,
  output logic [7:0]                   input_threshold_select_o,
  output logic [7:0]                   slew_limit_enable_o,
  output logic [7:0]                   open_drain_enable_o,
  output logic [7:0]                   current_drive_config_o,
  // Peripheral and analog sources.
  input  wire logic [7:0]              periph_en_i,
  input  wire logic [7:0]              periph_out_i,
  input  wire logic [7:0]              periph_oe_i,
  input  wire logic [7:0]              analog_out_en_i,
  // Device pins.
  input  wire logic [7:0]              pad_i,
  output logic [7:0]                   pad_o,
  output logic [7:0]                   pad_oe_o,
  // Pad controls.
  output logic [7:0]                   pad_ibuf_en_o,
  output logic [7:0]                   pad_analog_in_en_o,
  output logic [7:0]                   pad_pullup_o,
  output logic [7:0]                   pad_schmitt_o,
  output logic [7:0]                   pad_slew_o,
  output logic [7:0]                   pad_src_cc_o,
  output logic [7:0]                   pad_snk_cc_o,
  output iopc_pkg::iopc_level_t        cc_level_o,
  // Digital input to peripherals.
  output logic [7:0]                   periph_in_o
);
  import iopc_pkg::*;

  logic [7:0]  latch_q;
  logic [7:0]  dir_q;
  logic [7:0]  ansel_q;
  logic [7:0]  pull_q;
  logic [7:0]  srccc_q;
  logic [7:0]  snkcc_q;
  logic [7:0]  thr_q;
  logic [7:0]  slew_q;
  logic [7:0]  od_q;
  logic        cc_en_q;
  logic [1:0]  cc_lvl_q;
  wire  logic  latch_wr;
  wire  logic [7:0] src_sel;
  wire  logic [7:0] src_oe;
  wire  logic [7:0] drv_oe;
  wire  logic [7:0] pin_gated;

  iopc_pin_if pin_bus ();

  // Both latch and readback addresses write the latch.
  assign latch_wr = wr_latch_i | wr_readback_i; // [RL3]

  // Output latch; it sources every pin whose peripheral enable is clear.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      latch_q <= LATCH_RST; // [RL10]
    end else if (latch_wr) begin
      latch_q <= wr_data_i; // [RL3]
    end
  end

  // Direction; ones keep the drivers off on pins whose peripheral enable is clear, as they are after reset.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      dir_q <= DIR_RST;
    end else if (wr_dir_i) begin
      dir_q <= wr_data_i; // [RL1]
    end
  end

  // Analog select; pins come out of reset in analog mode.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      ansel_q <= ANSEL_RST;
    end else if (wr_ansel_i) begin
      ansel_q <= wr_data_i;
    end
  end

  // Weak pull-up enables, one bit per pin.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      pull_q <= ZERO_RST;
    end else if (wr_pullup_i) begin
      pull_q <= wr_data_i;
    end
  end

  // Source current control enables, one bit per pin.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      srccc_q <= ZERO_RST;
    end else if (wr_src_cc_i) begin
      srccc_q <= wr_data_i; // [RL9]
    end
  end

  // Sink current control enables, one bit per pin.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      snkcc_q <= ZERO_RST;
    end else if (wr_snk_cc_i) begin
      snkcc_q <= wr_data_i; // [RL9]
    end
  end

  // Input threshold selects.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      thr_q <= ZERO_RST;
    end else if (wr_thresh_i) begin
      thr_q <= wr_data_i;
    end
  end

  // Slew limit enables.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      slew_q <= ZERO_RST;
    end else if (wr_slew_i) begin
      slew_q <= wr_data_i;
    end
  end

  // Open-drain enables; a set bit lets the pin sink current only.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      od_q <= ZERO_RST;
    end else if (wr_odrain_i) begin
      od_q <= wr_data_i;
    end
  end

  // Global current drive configuration, bit 7 enable, bits 1:0 level.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      cc_en_q  <= CC_EN_RST;
      cc_lvl_q <= LEVEL_RST;
    end else if (wr_ccfg_i) begin
      cc_en_q  <= wr_data_i[CC_EN_POS]; // [RL8]
      cc_lvl_q <= wr_data_i[CC_LVL_POS +: LVL_W]; // [RL8]
    end
  end

  // Output source: peripheral when enabled, else the latch.
  assign src_sel = (periph_en_i & periph_out_i) |
                   (~periph_en_i & latch_q); // [RL2]
  assign src_oe  = (periph_en_i & periph_oe_i) |
                   (~periph_en_i & ~dir_q); // [RL14]
  // Analog output wins; analog select does not gate drive.
  assign drv_oe  = src_oe & ~analog_out_en_i; // [RL13] [RL12]
  // Open drain drives low only.
  assign pad_o    = src_sel & ~od_q;
  assign pad_oe_o = drv_oe & ~(od_q & src_sel);

  // Digital input buffer off in analog mode; analog path on.
  assign pad_ibuf_en_o      = ~ansel_q; // [RL5]
  assign pad_analog_in_en_o = ansel_q; // [RL11]
  assign pin_gated          = pad_i & ~ansel_q; // [RL15]
  assign pin_bus.raw        = pin_gated;

  iopc_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .pins      (pin_bus.sync)
  ); // [RL17]

  // Current control per driver, independent of the output source.
  assign pad_src_cc_o = srccc_q & {8{cc_en_q}}; // [RL6] [RL7]
  assign pad_snk_cc_o = snkcc_q & {8{cc_en_q}}; // [RL6] [RL7]
  assign cc_level_o   = iopc_level_t'(cc_lvl_q); // [RL16]

  // Remaining pad controls.
  assign pad_pullup_o  = pull_q;
  assign pad_schmitt_o = thr_q;
  assign pad_slew_o    = slew_q;
  assign periph_in_o   = pin_bus.synced; // [RL2]

  // Readback views for software.
  assign pin_level_readback_o          = pin_bus.synced; // [RL4]
  assign output_latch_o                = latch_q; // [RL4]
  assign direction_control_o           = dir_q;
  assign analog_select_o               = ansel_q;
  assign weak_pullup_enable_o          = pull_q;
  assign source_current_limit_enable_o = srccc_q;
  assign sink_current_limit_enable_o   = snkcc_q;
  assign input_threshold_select_o      = thr_q;
  assign slew_limit_enable_o           = slew_q;
  assign open_drain_enable_o           = od_q;
  assign current_drive_config_o        = {cc_en_q, 5'h00, cc_lvl_q};
endmodule

//--- core/iopc_sync.sv
`timescale 1ns/10ps
module iopc_sync (
  // Clock and reset.
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  // Pin levels.
  iopc_pin_if.sync  pins
);
  import iopc_pkg::*;

  logic [7:0] meta_q;
  logic [7:0] sync_q;

  // Two flops; the first is read only by the second.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      meta_q <= ZERO_RST;
      sync_q <= ZERO_RST;
    end else begin
      meta_q <= pins.raw;
      sync_q <= meta_q;
    end
  end

  assign pins.synced = sync_q;
endmodule

//--- inc/iopc_pin_if.sv
`timescale 1ns/10ps
interface iopc_pin_if;
  logic [7:0] raw;
  logic [7:0] synced;
  modport src (output raw, input synced);
  modport sync (input raw, output synced);
endinterface

//--- inc/iopc_pkg.sv
package iopc_pkg;
  localparam int unsigned PIN_W = 8;
  localparam int unsigned LVL_W = 2;
  // Values after reset.
  localparam logic [7:0] LATCH_RST  = 8'h00;
  localparam logic [7:0] DIR_RST    = 8'hFF;
  localparam logic [7:0] ANSEL_RST  = 8'hFF;
  localparam logic [7:0] ZERO_RST   = 8'h00;
  localparam logic [1:0] LEVEL_RST  = 2'h0;
  localparam logic       CC_EN_RST  = 1'h0;
  // Field positions in the global drive configuration.
  localparam int unsigned CC_EN_POS  = 7;
  localparam int unsigned CC_LVL_POS = 0;
  // Current level select encodings.
  typedef enum logic [1:0] {
    IOPC_LVL_10MA = 2'b00,
    IOPC_LVL_5MA  = 2'b01,
    IOPC_LVL_2MA  = 2'b10,
    IOPC_LVL_1MA  = 2'b11
  } iopc_level_t;
  // Synchroniser depth.
  localparam int unsigned SYNC_STAGES = 2;
endpackage

//--- verification/iopc_pads.sv
`timescale 1ns/10ps
module iopc_pads (
  // Clock, device drive and external load.
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] pad_o, pad_oe_o, pad_pullup_o, ext_val_i, ext_en_i,
  // Pin levels.
  output logic [7:0]      pad_i
);
  logic [7:0] flt_q = 8'h00;
  // A released pin with no external load and no pull-up shows a value that changes each cycle.
  always @(posedge sys_clk_i) flt_q <= ~flt_q;
  // Device drive first, then the external load, then pull-up or float.
  assign pad_i = (pad_oe_o & pad_o) | (~pad_oe_o & ext_en_i & ext_val_i) |
    (~pad_oe_o & ~ext_en_i & (pad_pullup_o | flt_q));
endmodule

//--- verification/iopc_port_tb.sv
`timescale 1ns/10ps
module iopc_port_tb;
  import iopc_pkg::*;
  logic sys_clk_i = 1'b0, nrst_i = 1'b0;
  logic [10:0] wr = '0;
  logic [7:0] wr_data_i = 8'h00, periph_en_i = 8'h00, periph_out_i = 8'h00;
  logic [7:0] periph_oe_i = 8'h00, analog_out_en_i = 8'h00, r, v, pad_i;
  logic [7:0] ext_val_i = 8'h00, ext_en_i = 8'h00, view [22];
  logic [7:0] pin_level_readback_o, output_latch_o, direction_control_o;
  logic [7:0] analog_select_o, weak_pullup_enable_o, slew_limit_enable_o;
  logic [7:0] source_current_limit_enable_o, sink_current_limit_enable_o;
  logic [7:0] input_threshold_select_o, open_drain_enable_o, pad_o, pad_oe_o;
  logic [7:0] current_drive_config_o, pad_ibuf_en_o, pad_analog_in_en_o;
  logic [7:0] pad_pullup_o, pad_schmitt_o, pad_slew_o, periph_in_o;
  logic [7:0] pad_src_cc_o, pad_snk_cc_o;
  // Names of the results, in the order of the view below.
  string vn [22] = '{"readback", "latch", "direction", "analog", "pullup",
    "src_en", "snk_en", "threshold", "slew", "odrain", "drive_cfg",
    "pad_out", "pad_oe", "ibuf_en", "pad_src_cc", "pad_snk_cc", "level",
    "periph_in", "analog_in", "pad_pullup", "pad_schmitt", "pad_slew"};
  iopc_level_t cc_level_o;
  logic [12:0] q [$];
  int errors = 0, samples_checked = 0, seed = 23;
  event go;
  wire wr_readback_i = wr[0], wr_latch_i = wr[1], wr_dir_i = wr[2];
  wire wr_ansel_i = wr[3], wr_pullup_i = wr[4], wr_src_cc_i = wr[5];
  wire wr_snk_cc_i = wr[6], wr_thresh_i = wr[7], wr_slew_i = wr[8];
  wire wr_odrain_i = wr[9], wr_ccfg_i = wr[10];
  iopc_port i_iopc_port (.*);
  iopc_pads i_iopc_pads (.*);
  // Results that the monitor can compare, by index.
  always_comb view = '{pin_level_readback_o, output_latch_o,
    direction_control_o, analog_select_o, weak_pullup_enable_o,
    source_current_limit_enable_o, sink_current_limit_enable_o,
    input_threshold_select_o, slew_limit_enable_o, open_drain_enable_o,
    current_drive_config_o, pad_o, pad_oe_o, pad_ibuf_en_o, pad_src_cc_o,
    pad_snk_cc_o, {6'h00, cc_level_o}, periph_in_o, pad_analog_in_en_o,
    pad_pullup_o, pad_schmitt_o, pad_slew_o};
  always #4 sys_clk_i = ~sys_clk_i;
  task automatic wr_reg(input int i, input logic [7:0] d);
    @(posedge sys_clk_i);
    wr[i] <= 1'b1;
    wr_data_i <= d;
    @(posedge sys_clk_i);
    wr[i] <= 1'b0;
    #1;
  endtask
  // Lets the pin synchroniser settle, then steps off the clock edge.
  task automatic settle;
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic note(input int i, input logic [7:0] e);
    q.push_back({i[4:0], e});
    -> go;
  endtask
  task automatic cmp(input logic [12:0] e);
    samples_checked++;
    if (view[e[12:8]] !== e[7:0]) begin
      errors++;
      $display("[ERR] %s exp %h got %h", vn[e[12:8]], e[7:0],
        view[e[12:8]]);
    end
  endtask
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // The monitor takes the oldest notes off the queue and compares them.
  always @(go) while (q.size() > 0) cmp(q.pop_front());
  // A hang counts as a mismatch.
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    errors++;
    final_report();
  end
  // Main sequence.
  initial begin
    repeat (10) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    #1;
    note(1, LATCH_RST);
    note(2, DIR_RST);
    note(3, ANSEL_RST);
    note(12, ZERO_RST);
    for (int i = 2; i < 11; i++) begin
      r = $random(seed);
      wr_reg(i, r);
      note(i, (i == 10) ? (r & 8'h83) : r);
      if (i == 3) note(18, r);
      if (i == 4) note(19, r);
      if (i == 7) note(20, r);
      if (i == 8) note(21, r);
    end
    r = $random(seed);
    wr_reg(1, r);
    note(1, r);
    wr_reg(0, ~r);
    note(1, ~r);
    $display("register test done");
    wr_reg(9, 8'h00);
    wr_reg(3, 8'h00);
    wr_reg(2, 8'h00);
    settle();
    note(11, ~r);
    note(0, ~r);
    wr_reg(3, 8'hF0);
    settle();
    note(0, ~r & 8'h0F);
    note(12, 8'hFF);
    note(13, 8'h0F);
    note(17, ~r & 8'h0F);
    note(18, 8'hF0);
    // Open drain: never drives high, drives only where the latch is low.
    wr_reg(9, 8'hFF);
    note(11, 8'h00);
    note(12, r);
    wr_reg(9, 8'h00);
    wr_reg(2, 8'hFF);
    v = $random(seed);
    @(posedge sys_clk_i);
    ext_val_i <= v;
    ext_en_i <= 8'hFF;
    settle();
    note(0, v & 8'h0F);
    $display("pin test done");
    r = $random(seed);
    @(posedge sys_clk_i);
    periph_en_i <= 8'h0F;
    periph_oe_i <= 8'h0F;
    periph_out_i <= r;
    analog_out_en_i <= 8'h01;
    wr_reg(2, 8'h00);
    settle();
    note(12, 8'hFE);
    note(0, {4'h0, r[3:1], v[0]});
    $display("peripheral test done");
    wr_reg(5, 8'h3C);
    wr_reg(6, 8'hC3);
    wr_reg(10, 8'h00);
    note(14, 8'h00);
    for (int l = 0; l < 4; l++) begin
      wr_reg(10, 8'h80 | l[7:0]);
      note(14, 8'h3C);
      note(15, 8'hC3);
      note(16, l[7:0]);
    end
    $display("current test done");
    #1;
    final_report();
  end
endmodule

//--- verification/iopc_props.sv
`timescale 1ns/10ps
module iopc_props (
  // Clock, reset and inputs.
  input wire logic       sys_clk_i, nrst_i, wr_latch_i, wr_readback_i,
  input wire logic       wr_ccfg_i,
  input wire logic [7:0] wr_data_i, pad_i, periph_en_i, periph_out_i,
  input wire logic [7:0] periph_oe_i, analog_out_en_i,
  // Outputs.
  input wire logic [7:0] pin_level_readback_o, output_latch_o, pad_o,
  input wire logic [7:0] direction_control_o, analog_select_o, pad_oe_o,
  input wire logic [7:0] open_drain_enable_o, current_drive_config_o,
  input wire logic [7:0] source_current_limit_enable_o, pad_ibuf_en_o,
  input wire logic [7:0] sink_current_limit_enable_o, pad_src_cc_o,
  input wire logic [7:0] pad_snk_cc_o
);
  // Push-pull pins owned by the latch or by a peripheral.
  wire [7:0] pp  = ~analog_out_en_i & ~open_drain_enable_o;
  wire [7:0] lat = pp & ~periph_en_i;
  wire [7:0] per = pp & periph_en_i;
  wire [7:0] ccm = {8{current_drive_config_o[7]}};
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // Out of reset with a steady analog mask for three edges.
  sequence s_sync_ok;
    (nrst_i && $stable(analog_select_o)) [*3];
  endsequence
  a_latch_load: assert property (
    wr_latch_i || wr_readback_i |=> output_latch_o == $past(wr_data_i))
    else $error("latch not loaded");
  a_sync_two: assert property (
    s_sync_ok |-> pin_level_readback_o == $past(pad_i & ~analog_select_o, 2))
    else $error("readback wrong");
  a_ibuf_gate: assert property (
    pad_ibuf_en_o == ~analog_select_o) else $error("input buffer wrong");
  a_analog_hiz: assert property (
    (pad_oe_o & analog_out_en_i) == 8'h00) else $error("analog not hiz");
  a_cc_gate: assert property (
    pad_src_cc_o == (source_current_limit_enable_o & ccm) &&
    pad_snk_cc_o == (sink_current_limit_enable_o & ccm))
    else $error("current control wrong");
  a_latch_drive: assert property (
    (pad_oe_o & lat) == (~direction_control_o & lat) &&
    (pad_o & lat & pad_oe_o) == (output_latch_o & lat & pad_oe_o))
    else $error("latch drive wrong");
  a_periph_own: assert property (
    (pad_oe_o & per) == (periph_oe_i & per) &&
    (pad_o & per & periph_oe_i) == (periph_out_i & per & periph_oe_i))
    else $error("peripheral drive wrong");
  a_cfg_load: assert property (
    wr_ccfg_i |=> current_drive_config_o == ($past(wr_data_i) & 8'h83))
    else $error("config not loaded");
endmodule
bind iopc_port iopc_props i_iopc_props (.*);
